// [rtl/dpt_core.v]
// dpt_core.v - dancer roller pid trim: mode select, input scaling, speed trim,
// limit and status flags, terminal outputs, axi4-lite register slave.
// assumes: all inputs synchronous to ref_clk; pid gains computed outside.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`include "dpt_map.vh"

module dpt_core (
   input wire ref_clk,
   input wire reset_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [4:0] input_term,
   input wire [11:0] adc_in4,
   input wire [15:0] main_speed_cmd,
   input wire main_from_term2,
   input wire [15:0] output_freq,
   input wire running,
   input wire rot_forward,
   input wire [15:0] pid_manip,
   output reg [15:0] freq_cmd,
   output reg [15:0] pid_deviation,
   output reg pid_enable,
   output reg upper_limit_flag,
   output reg lower_limit_flag,
   output reg forward_direction_flag,
   output reg [2:0] out_term
);

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   reg [7:0] mode_q;
   reg [15:0] setpt_q, upper_q, lower_q, bias_q, gain_q, therm_q;
   reg [1:0] range_q;
   reg [23:0] outfn_q;
   reg [31:0] infn_q;
   reg [7:0] infn4_q;
   reg [5:0] net_q;
   reg [31:0] misc_q;
   reg [7:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   reg [15:0] meas_q;
   reg [15:0] ratio_q;
   reg [15:0] base_q, snap_q;
   reg snap_use_q;
   reg active_q;

   // -------------------------------------------------------------------------
   // mode and select
   // -------------------------------------------------------------------------
   wire [39:0] in_codes = {infn4_q, infn_q};
   wire [4:0] term_lvl;
   wire [4:0] sel_assigned;
   genvar t;
   generate
      for (t = 0; t < 5; t = t + 1) begin : g_in
         assign term_lvl[t] = net_q[5] ? net_q[t] : input_term[t];
         assign sel_assigned[t] = (in_codes[t*8 +: 8] == `DPT_IN_PID_SEL);
      end
   endgenerate

   wire mode_ok = (mode_q >= `DPT_MODE_FIX_REV) && (mode_q <= `DPT_MODE_RAT_FWD);
   wire sel_on = (sel_assigned == 5'h00) ? 1'b1 : |(sel_assigned & term_lvl);
   wire active = mode_ok && sel_on;
   wire reverse_act = (mode_q == `DPT_MODE_FIX_REV) || (mode_q == `DPT_MODE_RAT_REV);
   wire ratio_mode = (mode_q == `DPT_MODE_RAT_REV) || (mode_q == `DPT_MODE_RAT_FWD);

   // -------------------------------------------------------------------------
   // input 4 scaling
   // -------------------------------------------------------------------------
   // range dependent scaling
   wire [11:0] raw_off = (range_q == `DPT_RANGE_MA) ?
                         ((adc_in4 > `DPT_ADC_4MA) ? adc_in4 - `DPT_ADC_4MA : 12'h000) :
                         adc_in4;
   wire [15:0] k_sel = (range_q == `DPT_RANGE_MA) ? `DPT_K_4_20MA :
                       (range_q == `DPT_RANGE_5V) ? `DPT_K_0_5V : `DPT_K_0_10V;
   wire [27:0] meas_prod = raw_off * k_sel;
   wire [11:0] meas_raw = meas_prod[27:`DPT_K_SHIFT];
   // clipped at 100 %: over-range on the 0-5V setting would read above full
   wire [15:0] meas_pct = ({4'h0, meas_raw} > `DPT_PCT_FULL) ? `DPT_PCT_FULL :
                          {4'h0, meas_raw};

   wire [15:0] sp_pct = (setpt_q == `DPT_NO_FUNC) ? `DPT_PCT_HALF : setpt_q;
   wire [15:0] dev = reverse_act ? sp_pct - meas_q : meas_q - sp_pct;

   // -------------------------------------------------------------------------
   // main speed and trim
   // -------------------------------------------------------------------------
   // thermistor owns terminal 2
   wire [15:0] main_eff = (main_from_term2 && (therm_q != `DPT_NO_FUNC)) ? 16'h0000 :
                          main_speed_cmd;
   wire take = active && !active_q && running;
   wire [15:0] base = take ? output_freq :
                      (snap_use_q && (main_eff == snap_q)) ? base_q : main_eff;
   wire span_ok = gain_q > bias_q;
   wire [15:0] span = span_ok ? gain_q - bias_q : 16'h0000;
   wire signed [32:0] fx_p = $signed(pid_manip) * $signed({1'b0, span});
   wire signed [48:0] fx_w = fx_p * $signed({1'b0, `DPT_INV1000});
   wire signed [28:0] fx_add = fx_w[48:`DPT_INV_SHIFT];
   wire signed [45:0] rt_p = fx_add * $signed({1'b0, ratio_q});
   wire signed [61:0] rt_w = rt_p * $signed({1'b0, `DPT_INV1000});
   wire signed [41:0] rt_add = rt_w[61:`DPT_INV_SHIFT];
   wire signed [41:0] trim = ratio_mode ? rt_add : {{13{fx_add[28]}}, fx_add};
   wire signed [42:0] sum = $signed({27'h000_0000, base}) + trim;
   wire [15:0] sum_sat = sum[42] ? 16'h0000 : (|sum[41:16]) ? 16'hFFFF : sum[15:0];

   // -------------------------------------------------------------------------
   // ratio of main speed
   // -------------------------------------------------------------------------
   wire div_busy, div_done;
   wire [25:0] div_quo;
   wire below_bias = base <= bias_q;
   wire [15:0] main_off = base - bias_q;
   wire [25:0] div_num = main_off * `DPT_PCT_FULL;

   dpt_div u_div (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .start(span_ok && !below_bias),
      .num(div_num),
      .den(span),
      .busy(div_busy),
      .done_q(div_done),
      .quo_q(div_quo)
   );

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ratio_q <= `DPT_RST_ZERO16;
      end else if (!span_ok || below_bias) begin
         ratio_q <= `DPT_RST_ZERO16;
      end else if (div_done) begin
         ratio_q <= (div_quo > {10'h000, `DPT_PCT_FULL}) ? `DPT_PCT_FULL : div_quo[15:0];
      end
   end

   // -------------------------------------------------------------------------
   // flags and terminal outputs
   // -------------------------------------------------------------------------
   // upper and lower limit compare
   wire up_f = mode_ok && (upper_q != `DPT_NO_FUNC) && (meas_q > upper_q);
   wire lo_f = mode_ok && (lower_q != `DPT_NO_FUNC) && (meas_q < lower_q);
   wire dir_f = running && rot_forward;
   wire [2:0] term_d;
   genvar o;
   generate
      for (o = 0; o < 3; o = o + 1) begin : g_out
         wire [7:0] code = outfn_q[o*8 +: 8];
         wire neg = code >= `DPT_OUT_NEG;
         wire [7:0] bcode = neg ? code - `DPT_OUT_NEG : code;
         wire f = (bcode == `DPT_OUT_UPPER) ? up_f :
                  (bcode == `DPT_OUT_LOWER) ? lo_f :
                  (bcode == `DPT_OUT_DIR) ? dir_f :
                  (bcode == `DPT_OUT_PID) ? active : 1'b0;
         assign term_d[o] = neg ? ~f : f;
      end
   endgenerate

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meas_q <= `DPT_RST_ZERO16;
         active_q <= 1'b0;
         base_q <= `DPT_RST_ZERO16;
         snap_q <= `DPT_RST_ZERO16;
         snap_use_q <= 1'b0;
         freq_cmd <= `DPT_RST_ZERO16;
         pid_deviation <= `DPT_RST_ZERO16;
         pid_enable <= 1'b0;
         upper_limit_flag <= 1'b0;
         lower_limit_flag <= 1'b0;
         forward_direction_flag <= 1'b0;
         out_term <= 3'h0;
      end else begin
         meas_q <= meas_pct;
         active_q <= active;
         if (take) begin
            base_q <= output_freq;
            snap_q <= main_eff;
            snap_use_q <= 1'b1;
         end else if (!active || (main_eff != snap_q)) begin
            // a new main command from the operator ends the takeover
            snap_use_q <= 1'b0;
         end
         freq_cmd <= active ? sum_sat : main_eff;
         pid_deviation <= active ? dev : 16'h0000;
         pid_enable <= active;
         upper_limit_flag <= up_f;
         lower_limit_flag <= lo_f;
         forward_direction_flag <= dir_f;
         out_term <= term_d;
      end
   end

   // -------------------------------------------------------------------------
   // axi4-lite write channel
   // -------------------------------------------------------------------------
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   wire do_wr = aw_have_q && w_have_q;
   wire [7:0] wa = aw_addr_q;
   wire wa_ok = (wa <= `DPT_OFS_MISC) && (wa[1:0] == 2'h0);
   // byte lanes of the pending write
   wire [31:0] wm = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_addr_q <= 8'h00;
         aw_have_q <= 1'b0;
         w_data_q <= `DPT_RST_ZERO32;
         w_strb_q <= 4'h0;
         w_have_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DPT_RESP_OKAY;
         mode_q <= `DPT_RST_MODE;
         setpt_q <= `DPT_RST_9999;
         upper_q <= `DPT_RST_9999;
         lower_q <= `DPT_RST_9999;
         range_q <= `DPT_RANGE_MA;
         bias_q <= `DPT_RST_ZERO16;
         gain_q <= `DPT_RST_GAIN;
         outfn_q <= 24'h00_0000;
         infn_q <= `DPT_RST_ZERO32;
         infn4_q <= 8'h00;
         net_q <= 6'h00;
         therm_q <= `DPT_RST_9999;
         misc_q <= `DPT_RST_MISC;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_ok ? `DPT_RESP_OKAY : `DPT_RESP_SLVERR;
            case (wa)
               `DPT_OFS_MODE: mode_q <= (mode_q & ~wm[7:0]) | (w_data_q[7:0] & wm[7:0]);
               `DPT_OFS_SETPT: setpt_q <= (setpt_q & ~wm[15:0]) | (w_data_q[15:0] & wm[15:0]);
               `DPT_OFS_UPPER: upper_q <= (upper_q & ~wm[15:0]) | (w_data_q[15:0] & wm[15:0]);
               `DPT_OFS_LOWER: lower_q <= (lower_q & ~wm[15:0]) | (w_data_q[15:0] & wm[15:0]);
               `DPT_OFS_RANGE: range_q <= (range_q & ~wm[1:0]) | (w_data_q[1:0] & wm[1:0]);
               `DPT_OFS_BIAS: bias_q <= (bias_q & ~wm[15:0]) | (w_data_q[15:0] & wm[15:0]);
               `DPT_OFS_GAIN: gain_q <= (gain_q & ~wm[15:0]) | (w_data_q[15:0] & wm[15:0]);
               `DPT_OFS_OUTFN: outfn_q <= (outfn_q & ~wm[23:0]) | (w_data_q[23:0] & wm[23:0]);
               `DPT_OFS_INFN: infn_q <= (infn_q & ~wm) | (w_data_q & wm);
               `DPT_OFS_NET: begin
                  infn4_q <= (infn4_q & ~wm[23:16]) | (w_data_q[23:16] & wm[23:16]);
                  net_q <= (net_q & ~wm[5:0]) | (w_data_q[5:0] & wm[5:0]);
               end
               `DPT_OFS_THERM: therm_q <= (therm_q & ~wm[15:0]) | (w_data_q[15:0] & wm[15:0]);
               `DPT_OFS_MISC: misc_q <= (misc_q & ~wm) | (w_data_q & wm);
               default: ;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // axi4-lite read channel
   // -------------------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   reg [31:0] rd_d;
   reg rd_ok;

   always @* begin
      rd_d = `DPT_RST_ZERO32;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `DPT_OFS_MODE: rd_d = {24'h00_0000, mode_q};
         `DPT_OFS_SETPT: rd_d = {16'h0000, setpt_q};
         `DPT_OFS_UPPER: rd_d = {16'h0000, upper_q};
         `DPT_OFS_LOWER: rd_d = {16'h0000, lower_q};
         `DPT_OFS_RANGE: rd_d = {30'h0000_0000, range_q};
         `DPT_OFS_BIAS: rd_d = {16'h0000, bias_q};
         `DPT_OFS_GAIN: rd_d = {16'h0000, gain_q};
         `DPT_OFS_OUTFN: rd_d = {8'h00, outfn_q};
         `DPT_OFS_INFN: rd_d = infn_q;
         `DPT_OFS_NET: rd_d = {8'h00, infn4_q, 10'h000, net_q};
         `DPT_OFS_THERM: rd_d = {16'h0000, therm_q};
         `DPT_OFS_MISC: rd_d = misc_q;
         `DPT_OFS_STAT: rd_d = {meas_q, 6'h00, div_busy, ratio_mode, sel_on, out_term,
                                forward_direction_flag, lower_limit_flag,
                                upper_limit_flag, pid_enable};
         `DPT_OFS_FREQ: rd_d = {ratio_q, freq_cmd};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `DPT_RST_ZERO32;
         s_axi_rresp <= `DPT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= rd_ok ? `DPT_RESP_OKAY : `DPT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // dpt_core

// [rtl/dpt_map.vh]
// dpt_map.vh - register map, reset values, codes and scaling constants for the
// dancer trim block.
// assumes: included by the dancer trim design files only.
`ifndef DPT_MAP_VH
`define DPT_MAP_VH

// -----------------------------------------------------------------------------
// register byte offsets (axi4-lite, one aligned word each)
// -----------------------------------------------------------------------------
`define DPT_OFS_MODE 8'h00
`define DPT_OFS_SETPT 8'h04
`define DPT_OFS_UPPER 8'h08
`define DPT_OFS_LOWER 8'h0C
`define DPT_OFS_RANGE 8'h10
`define DPT_OFS_BIAS 8'h14
`define DPT_OFS_GAIN 8'h18
`define DPT_OFS_OUTFN 8'h1C
`define DPT_OFS_INFN 8'h20
`define DPT_OFS_NET 8'h24
`define DPT_OFS_THERM 8'h28
`define DPT_OFS_MISC 8'h2C
`define DPT_OFS_STAT 8'h40
`define DPT_OFS_FREQ 8'h44

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define DPT_RST_MODE 8'h00
`define DPT_RST_9999 16'h270F
`define DPT_RST_GAIN 16'h1388
`define DPT_RST_ZERO16 16'h0000
`define DPT_RST_ZERO32 32'h0000_0000
`define DPT_RST_MISC 32'h270F_270F

// -----------------------------------------------------------------------------
// action codes, terminal function codes
// -----------------------------------------------------------------------------
`define DPT_MODE_OFF 8'h00
`define DPT_MODE_FIX_REV 8'h28
`define DPT_MODE_FIX_FWD 8'h29
`define DPT_MODE_RAT_REV 8'h2A
`define DPT_MODE_RAT_FWD 8'h2B
`define DPT_IN_PID_SEL 8'h0E
`define DPT_OUT_LOWER 8'h0E
`define DPT_OUT_UPPER 8'h0F
`define DPT_OUT_DIR 8'h10
`define DPT_OUT_PID 8'h2F
`define DPT_OUT_NEG 8'h64
`define DPT_NO_FUNC 16'h270F

// -----------------------------------------------------------------------------
// scaling, percentages in 0.1 % steps, adc full scale 4095 = 20mA / 10V
// -----------------------------------------------------------------------------
`define DPT_PCT_FULL 16'h03E8
`define DPT_PCT_HALF 16'h01F4
`define DPT_ADC_4MA 12'h0333
`define DPT_K_4_20MA 16'h4E25
`define DPT_K_0_5V 16'h7D08
`define DPT_K_0_10V 16'h3E84
`define DPT_RANGE_MA 2'h0
`define DPT_RANGE_5V 2'h1
`define DPT_INV1000 16'h0419
`define DPT_INV_SHIFT 20
`define DPT_K_SHIFT 16
`define DPT_DIV_STEPS 5'h1A
`define DPT_RESP_OKAY 2'h0
`define DPT_RESP_SLVERR 2'h2

`endif

// [rtl/dpt_div.v]
// dpt_div.v - serial restoring divider, one quotient bit per clock.
// assumes: den is nonzero while start is high; inputs held only at start.
`include "dpt_map.vh"

module dpt_div (
   input wire ref_clk,
   input wire reset_n,
   input wire start,
   input wire [25:0] num,
   input wire [15:0] den,
   output wire busy,
   output reg done_q,
   output reg [25:0] quo_q
);

   reg [25:0] n_q;
   reg [16:0] rem_q;
   reg [15:0] den_q;
   reg [4:0] cnt_q;
   // one extra bit keeps the borrow honest for divisors above half scale
   wire [17:0] trial;

   assign busy = (cnt_q != 5'h00);
   assign trial = {rem_q, n_q[25]} - {2'b00, den_q};

   // -------------------------------------------------------------------------
   // shift and subtract
   // -------------------------------------------------------------------------
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         n_q <= 26'h000_0000;
         rem_q <= 17'h0_0000;
         den_q <= 16'h0000;
         cnt_q <= 5'h00;
         done_q <= 1'b0;
         quo_q <= 26'h000_0000;
      end else begin
         done_q <= 1'b0;
         if (cnt_q == 5'h00) begin
            if (start) begin
               n_q <= num;
               den_q <= den;
               rem_q <= 17'h0_0000;
               cnt_q <= `DPT_DIV_STEPS;
            end
         end else begin
            if (!trial[17]) begin
               rem_q <= trial[16:0];
            end else begin
               rem_q <= {rem_q[15:0], n_q[25]};
            end
            n_q <= {n_q[24:0], ~trial[17]};
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               done_q <= 1'b1;
               quo_q <= {n_q[24:0], ~trial[17]};
            end
         end
      end
   end

endmodule // dpt_div

// [test/dpt_core_assertions.sv]
// dpt_core_assertions.sv - concurrent checks on the dpt_core ports.
// assumes: bound to dpt_core; one clock domain, ref_clk.
module dpt_chk (
   input wire ref_clk,
   input wire reset_n,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire running,
   input wire rot_forward,
   input wire [15:0] pid_deviation,
   input wire pid_enable,
   input wire forward_direction_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // bus handshakes
   // ----------------------------------------
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("no write response");
   read_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("no read response");
   wr_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
      else $error("bad write response code");
   // ----------------------------------------
   // device flags
   // ----------------------------------------
   dir_flag_a: assert property ($past(reset_n) |-> forward_direction_flag == $past(running && rot_forward))
      else $error("direction flag wrong");
   idle_dev_a: assert property (!pid_enable |-> pid_deviation == 16'h0000)
      else $error("deviation while idle");
endmodule // dpt_chk

bind dpt_core dpt_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .running(running), .rot_forward(rot_forward), .pid_deviation(pid_deviation),
   .pid_enable(pid_enable), .forward_direction_flag(forward_direction_flag));

// [test/dpt_plant.sv]
// dpt_plant.sv - dancer position sensor and drive model.
// assumes: bench sets position and run state; slow freezes the drive speed.
module dpt_plant (
   input wire ref_clk,
   input wire [15:0] freq_cmd,
   input wire slow,
   input wire [11:0] pos,
   input wire run,
   input wire fwd,
   output logic [11:0] adc_in4 = 12'h000,
   output logic [15:0] output_freq = 16'h0000,
   output logic running = 1'b0,
   output logic rot_forward = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // a slow drive lags its command, which is what exposes the speed adoption
   always @(posedge ref_clk) begin
      adc_in4 <= pos;
      running <= run;
      rot_forward <= fwd;
      if (!slow) begin
         output_freq <= run ? freq_cmd : 16'h0000;
      end
   end
endmodule // dpt_plant

// [test/test_dancer_pid_speed_trim.sv]
// test_dancer_pid_speed_trim.sv - bus driven bench for dpt_core.
// assumes: dpt_chk bound from its own file; dpt_plant drives the sensor side.
module test_dancer_pid_speed_trim;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [4:0] in_t = 0;
   logic [15:0] main = 0, manip = 0, d0;
   logic from2 = 0, slow = 0, run = 0, fwd = 0;
   logic [11:0] pos = 0;
   wire awready, wready, bvalid, arready, rvalid, runw, fwdw, pen, upf, lof, dirf;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [11:0] adc;
   wire [15:0] ofreq, fcmd, dev;
   wire [2:0] ot;
   int err_count = 0, cmp_count = 0;
   dpt_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .input_term(in_t),
      .adc_in4(adc), .main_speed_cmd(main), .main_from_term2(from2), .output_freq(ofreq),
      .running(runw), .rot_forward(fwdw), .pid_manip(manip), .freq_cmd(fcmd),
      .pid_deviation(dev), .pid_enable(pen), .upper_limit_flag(upf),
      .lower_limit_flag(lof), .forward_direction_flag(dirf), .out_term(ot));
   dpt_plant u_plant (.ref_clk(ref_clk), .freq_cmd(fcmd), .slow(slow), .pos(pos), .run(run),
      .fwd(fwd), .adc_in4(adc), .output_freq(ofreq), .running(runw), .rot_forward(fwdw));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // write and read wait for the answer; the watchdog ends a hang
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      bready <= 0;
      chk("bresp", bresp, r);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r = 2'h0);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      rready <= 0;
      chk("rresp", rresp, r);
      chk("rdata", rdata, e);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      err_count++;
      print_verdict();
   end
   initial begin
      cyc(2);
      reset_n <= 1;
      rd(8'h04, 32'h270F);
      rd(8'h18, 32'h1388);
      rd(8'h2C, 32'h270F_270F);
      wr(8'h30, 32'h1, 2'h2);
      wr(8'h40, 32'h1, 2'h2);
      rd(8'h3C, 32'h0, 2'h2);
      $display("test registers done");
      main <= 16'h07D0;
      run <= 1;
      fwd <= 1;
      wr(8'h1C, 32'h10_932F);
      cyc(40);
      chk("freq_cmd", fcmd, 32'h07D0);
      chk("out_term", ot, 32'h6);
      chk("dir", dirf, 1);
      for (int i = 0; i < 6; i++) begin
         wr(8'h00, 32'h27 + i);
         cyc(40);
         chk("pid_enable", pen, i > 0 && i < 5);
      end
      manip <= 16'h0064;
      wr(8'h00, 32'h29);
      cyc(40);
      chk("fixed trim", fcmd, 32'h09C4);
      chk("out_term", ot, 32'h5);
      wr(8'h00, 32'h2B);
      for (int i = 0; i < 3; i++) begin
         wr(8'h14, i == 2 ? 32'h3E8 : 32'h0);
         main <= i == 0 ? 16'h09C4 : i == 1 ? 16'h1388 : 16'h0320;
         cyc(60);
         chk("ratio trim", fcmd, i == 0 ? 32'h0ABE : i == 1 ? 32'h157C : 32'h0320);
      end
      wr(8'h14, 32'h0);
      $display("test trim done");
      wr(8'h08, 32'h1F4);
      wr(8'h0C, 32'h64);
      for (int i = 0; i < 6; i++) begin
         wr(8'h10, i / 2);
         pos <= i == 0 ? 12'h333 : i == 1 ? 12'hFFF : i == 2 ? 12'h400 : i == 3 ? 12'h7FF : i == 4 ? 12'h0 : 12'hFFF;
         cyc(10);
         chk("limits", {upf, lof}, i == 0 || i == 4 ? 2 'h1 : i == 2 ? 2'h0 : 2'h2);
      end
      wr(8'h1C, 32'h0F_720E);
      cyc(4);
      chk("limit terms", ot, 32'h6);
      pos <= 12'h800;
      cyc(10);
      chk("deviation", dev, 32'h0);
      wr(8'h04, 32'h12C);
      cyc(10);
      d0 = dev;
      chk("deviation size", d0 == 16'h00C8 || d0 == 16'hFF38, 1);
      wr(8'h00, 32'h28);
      cyc(10);
      chk("deviation sign", dev, 16'(-d0));
      $display("test measure done");
      manip <= 16'h0;
      main <= 16'h07D0;
      wr(8'h00, 32'h29);
      wr(8'h20, 32'h0E);
      cyc(10);
      chk("select off", pen, 0);
      slow <= 1;
      main <= 16'h0BB8;
      in_t <= 5'h01;
      cyc(10);
      chk("adopt speed", fcmd, 32'h07D0);
      in_t <= 5'h00;
      cyc(10);
      chk("leave dancer", fcmd, 32'h0BB8);
      slow <= 0;
      wr(8'h24, 32'h21);
      cyc(10);
      chk("net select", pen, 1);
      wr(8'h24, 32'h20);
      cyc(10);
      chk("net deselect", pen, 0);
      wr(8'h00, 32'h0);
      wr(8'h28, 32'h0);
      from2 <= 1;
      run <= 0;
      cyc(10);
      chk("therm main", fcmd, 32'h0);
      chk("flags idle", {upf, lof, dirf}, 0);
      $display("test select done");
      print_verdict();
   end
endmodule // test_dancer_pid_speed_trim
